//--- logic/sdcc_consts.vh
// Purpose: Shared constants of the command and clock-enable decoder
// Assumes: Address bus of 12 bits, two banks
// Notes: Included by bare name
`ifndef SDCC_CONSTS_VH
`define SDCC_CONSTS_VH
// Address field positions and bus width
`define SDCC_BANK_SEL_BIT 11
`define SDCC_AUTOCLOSE_BIT 10
`define SDCC_ADDR_W 12
// Device states
`define SDCC_DEV_NORMAL 3'h0
`define SDCC_DEV_SELF 3'h1
`define SDCC_DEV_SREC 3'h2
`define SDCC_DEV_PDOWN 3'h3
`define SDCC_DEV_SUSP 3'h4
// Bank states
`define SDCC_BK_IDLE 3'h0
`define SDCC_BK_ACTIVE 3'h1
`define SDCC_BK_READ 3'h2
`define SDCC_BK_WRITE 3'h3
`define SDCC_BK_RDAC 3'h4
`define SDCC_BK_WRAC 3'h5
// Commands
`define SDCC_CMD_DESEL 4'h0
`define SDCC_CMD_IDLE 4'h1
`define SDCC_CMD_HALT 4'h2
`define SDCC_CMD_FETCH 4'h3
`define SDCC_CMD_STORE 4'h4
`define SDCC_CMD_OPEN 4'h5
`define SDCC_CMD_CLOSE 4'h6
`define SDCC_CMD_REFR 4'h7
`define SDCC_CMD_CFG 4'h8
// Timing in ns and cycles, and default burst length
`define SDCC_ROW_CYCLE_NS 60
`define SDCC_CLK_NS 5
`define SDCC_ROW_CYCLE_CYC ((`SDCC_ROW_CYCLE_NS+`SDCC_CLK_NS-1)/`SDCC_CLK_NS)
`define SDCC_BURST_LEN 4
`endif

//--- logic/sdcc_bank.v
// Purpose: State of one bank
// Assumes: Commands already decoded and gated to this bank, except halt, which reaches both banks ungated, and close with auto-close set, which reaches both
// Notes: Auto-close states fall to idle when the burst ends
`timescale 1ns/1ps
`include "sdcc_consts.vh"
module sdcc_bank #(
   parameter BURST_LEN = `SDCC_BURST_LEN
) (
   input wire clk,
   input wire rst_b,
   input wire run,
   input wire do_open,
   input wire do_fetch,
   input wire do_store,
   input wire do_halt,
   input wire do_close,
   input wire autoclose,
   output reg [2:0] state
);
   reg [7:0] beat;
   reg [2:0] next_state;
   reg [7:0] next_beat;
   // ----------------------------------------------
   // Next bank state
   // ----------------------------------------------
   always @* begin
      next_state = state;
      next_beat = beat;
      if (do_close) begin
         next_state = `SDCC_BK_IDLE;
      end else if (do_open && state == `SDCC_BK_IDLE) begin
         next_state = `SDCC_BK_ACTIVE;
      end else if ((do_fetch || do_store) && state != `SDCC_BK_IDLE) begin
         next_beat = 8'h00;
         if (do_fetch) begin
            next_state = autoclose ? `SDCC_BK_RDAC : `SDCC_BK_READ;
         end else begin
            next_state = autoclose ? `SDCC_BK_WRAC : `SDCC_BK_WRITE;
         end
      end else if (do_halt && (state == `SDCC_BK_READ ||
                               state == `SDCC_BK_WRITE)) begin
         next_state = `SDCC_BK_ACTIVE;
      end else if (state >= `SDCC_BK_READ) begin
         next_beat = beat + 8'h01;
         if (beat == BURST_LEN - 1) begin
            // Burst done: plain ones stay open, auto-close ones precharge
            next_state = (state >= `SDCC_BK_RDAC) ? `SDCC_BK_IDLE :
                         `SDCC_BK_ACTIVE;
         end
      end
   end
   // Bank register, frozen while not running
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= `SDCC_BK_IDLE;
         beat <= 8'h00;
      end else if (run) begin
         state <= next_state;
         beat <= next_beat;
      end
   end
endmodule // sdcc_bank

//--- logic/sdcc_decode.v
// Purpose: Command and clock-enable decoder of a two-bank SDRAM
// Assumes: Controller keeps wake setup time and idles banks before
//          low-power entry
// Notes: Strobe pins are active low
`timescale 1ns/1ps
`include "sdcc_consts.vh"
module sdcc_decode #(
   parameter ROW_CYCLES = `SDCC_ROW_CYCLE_CYC,
   parameter BURST_LEN = `SDCC_BURST_LEN
) (
   input wire clk,
   input wire rst_b,
   input wire cke,
   input wire cs_b,
   input wire ras_b,
   input wire cas_b,
   input wire we_b,
   input wire [11:0] addr,
   output reg [2:0] dev_state,
   output reg [2:0] bank0_state,
   output reg [2:0] bank1_state,
   output reg [11:0] config_word,
   output reg [10:0] row_addr,
   output reg [9:0] col_addr,
   output reg cmd_bank,
   output reg illegal_cmd,
   output reg refresh_pulse,
   output reg input_active
);
   // ----------------------------------------------
   // Input synchronisers
   // ----------------------------------------------
   reg cke_s1, cke_s2, cke_prev;
   reg [3:0] strb_s1, strb_s2;
   reg [11:0] addr_s1, addr_s2;
   reg [2:0] state;
   reg [7:0] tmr;
   reg [2:0] next_state;
   reg [7:0] next_tmr;
   reg next_illegal, next_refresh, bank_run;
   reg open_c, fetch_c, store_c, halt_c, close_c;
   wire [2:0] b0_state, b1_state;
   wire [3:0] cmd;
   wire bsel, acl, cke_n, cke_p;

   // Decode strobes (cs, ras, cas, we) into a command code
   function [3:0] sdcc_cmd_of;
      input [3:0] s;
      begin
         casez (s)
            4'b1???: sdcc_cmd_of = `SDCC_CMD_DESEL;
            4'b0111: sdcc_cmd_of = `SDCC_CMD_IDLE;
            4'b0110: sdcc_cmd_of = `SDCC_CMD_HALT;
            4'b0101: sdcc_cmd_of = `SDCC_CMD_FETCH;
            4'b0100: sdcc_cmd_of = `SDCC_CMD_STORE;
            4'b0011: sdcc_cmd_of = `SDCC_CMD_OPEN;
            4'b0010: sdcc_cmd_of = `SDCC_CMD_CLOSE;
            4'b0001: sdcc_cmd_of = `SDCC_CMD_REFR;
            default: sdcc_cmd_of = `SDCC_CMD_CFG;
         endcase
      end
   endfunction

   // Deselect or idle pattern
   function sdcc_quiet;
      input [3:0] c;
      begin
         sdcc_quiet = (c == `SDCC_CMD_DESEL) || (c == `SDCC_CMD_IDLE);
      end
   endfunction

   // Two-flop capture of pins, plus last-cycle enable
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cke_s1 <= 1'b0;
         cke_s2 <= 1'b0;
         cke_prev <= 1'b0;
         strb_s1 <= 4'hF;
         strb_s2 <= 4'hF;
         addr_s1 <= 12'h000;
         addr_s2 <= 12'h000;
      end else begin
         cke_s1 <= cke;
         cke_s2 <= cke_s1;
         cke_prev <= cke_s2;
         strb_s1 <= {cs_b, ras_b, cas_b, we_b};
         strb_s2 <= strb_s1;
         addr_s1 <= addr;
         addr_s2 <= addr_s1;
      end
   end

   assign cke_n = cke_s2;
   assign cke_p = cke_prev;
   assign cmd = sdcc_cmd_of(strb_s2);
   assign bsel = addr_s2[`SDCC_BANK_SEL_BIT];
   assign acl = addr_s2[`SDCC_AUTOCLOSE_BIT];

   // ----------------------------------------------
   // Device state machine
   // ----------------------------------------------
   always @* begin
      next_state = state;
      next_tmr = tmr;
      next_illegal = 1'b0;
      next_refresh = 1'b0;
      bank_run = 1'b0;
      open_c = 1'b0;
      fetch_c = 1'b0;
      store_c = 1'b0;
      halt_c = 1'b0;
      close_c = 1'b0;
      case (state)
         `SDCC_DEV_SELF: begin
            // Only enable decides the exit; the command on the wake cycle is flagged if not quiet; rows refresh internally
            next_refresh = 1'b1;
            if (!cke_p && cke_n) begin
               next_state = `SDCC_DEV_SREC;
               next_tmr = 8'h00;
               next_illegal = !sdcc_quiet(cmd);
            end
         end
         `SDCC_DEV_SREC: begin
            if (!sdcc_quiet(cmd)) begin
               next_illegal = cke_p;
            end else if (cke_p && !cke_n) begin
               next_state = `SDCC_DEV_PDOWN;
            end else if (cke_p && cke_n) begin
               next_tmr = tmr + 8'h01;
               if (tmr >= ROW_CYCLES - 1) begin
                  next_state = `SDCC_DEV_NORMAL;
               end
            end
         end
         `SDCC_DEV_PDOWN: begin
            if (cke_n) begin
               next_state = `SDCC_DEV_NORMAL;
            end
         end
         `SDCC_DEV_SUSP: begin
            if (cke_n) begin
               next_state = `SDCC_DEV_NORMAL;
            end
         end
         default: begin
            if (b0_state == `SDCC_BK_IDLE && b1_state == `SDCC_BK_IDLE &&
                cke_p) begin
               if (!cke_n) begin
                  next_state = (cmd == `SDCC_CMD_REFR) ?
                               `SDCC_DEV_SELF : `SDCC_DEV_PDOWN;
               end else begin
                  bank_run = 1'b1;
                  next_refresh = (cmd == `SDCC_CMD_REFR);
                  open_c = (cmd == `SDCC_CMD_OPEN);
                  close_c = (cmd == `SDCC_CMD_CLOSE);
               end
            end else if (cke_p && !cke_n) begin
               next_state = `SDCC_DEV_SUSP;
            end else begin
               bank_run = 1'b1;
               open_c = (cmd == `SDCC_CMD_OPEN);
               fetch_c = (cmd == `SDCC_CMD_FETCH);
               store_c = (cmd == `SDCC_CMD_STORE);
               halt_c = (cmd == `SDCC_CMD_HALT);
               close_c = (cmd == `SDCC_CMD_CLOSE);
               next_illegal = (cmd == `SDCC_CMD_REFR) ||
                              (cmd == `SDCC_CMD_CFG);
            end
         end
      endcase
   end

   // State, timer and output flops
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= `SDCC_DEV_NORMAL;
         tmr <= 8'h00;
         dev_state <= `SDCC_DEV_NORMAL;
         bank0_state <= `SDCC_BK_IDLE;
         bank1_state <= `SDCC_BK_IDLE;
         config_word <= 12'h000;
         row_addr <= 11'h000;
         col_addr <= 10'h000;
         cmd_bank <= 1'b0;
         illegal_cmd <= 1'b0;
         refresh_pulse <= 1'b0;
         input_active <= 1'b0;
      end else begin
         state <= next_state;
         tmr <= next_tmr;
         dev_state <= next_state;
         bank0_state <= b0_state;
         bank1_state <= b1_state;
         illegal_cmd <= next_illegal;
         refresh_pulse <= next_refresh;
         // Inputs count as awake whenever enable is high
         input_active <= cke_n;
         if (bank_run && cmd == `SDCC_CMD_CFG &&
             b0_state == `SDCC_BK_IDLE && b1_state == `SDCC_BK_IDLE) begin
            config_word <= addr_s2;
         end
         if (open_c) begin
            row_addr <= addr_s2[10:0];
            cmd_bank <= bsel;
         end
         if (fetch_c || store_c) begin
            col_addr <= addr_s2[9:0];
            cmd_bank <= bsel;
         end
      end
   end

   // ----------------------------------------------
   // Banks
   // ----------------------------------------------
   sdcc_bank #(.BURST_LEN(BURST_LEN)) u_bank0 (
      .clk(clk),
      .rst_b(rst_b),
      .run(bank_run),
      .do_open(open_c && !bsel),
      .do_fetch(fetch_c && !bsel),
      .do_store(store_c && !bsel),
      .do_halt(halt_c),
      .do_close(close_c && (acl || !bsel)),
      .autoclose(acl),
      .state(b0_state)
   );
   sdcc_bank #(.BURST_LEN(BURST_LEN)) u_bank1 (
      .clk(clk),
      .rst_b(rst_b),
      .run(bank_run),
      .do_open(open_c && bsel),
      .do_fetch(fetch_c && bsel),
      .do_store(store_c && bsel),
      .do_halt(halt_c),
      .do_close(close_c && (acl || bsel)),
      .autoclose(acl),
      .state(b1_state)
   );
endmodule // sdcc_decode

//--- tb/sdcc_decode_assertions.sv
// Purpose: Port assertions of the command and enable decoder
// Assumes: Pins change away from the rising edge
// Notes: Bound to sdcc_decode below
`timescale 1ns/1ps
`include "sdcc_consts.vh"
module sdcc_decode_assertions #(
   parameter ROW_CYCLES = 3,
   parameter BURST_LEN = 4
) (
   input wire clk,
   input wire rst_b,
   input wire cke,
   input wire cs_b,
   input wire ras_b,
   input wire cas_b,
   input wire we_b,
   input wire [11:0] addr,
   input wire [2:0] dev_state,
   input wire [2:0] bank0_state,
   input wire [2:0] bank1_state,
   input wire cmd_bank,
   input wire refresh_pulse,
   input wire input_active
);
   // ------------------------------
   // Decoded views and recovery count
   // ------------------------------
   wire nrm = dev_state == `SDCC_DEV_NORMAL;
   wire slf = dev_state == `SDCC_DEV_SELF;
   wire srec = dev_state == `SDCC_DEV_SREC;
   wire pdn = dev_state == `SDCC_DEV_PDOWN;
   wire sus = dev_state == `SDCC_DEV_SUSP;
   wire rfp = !cs_b && !ras_b && !cas_b && we_b;
   wire idl = bank0_state == 3'h0 && bank1_state == 3'h0;
   reg [7:0] cnt;
   // Counts cycles spent in recovery
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b)
         cnt <= 8'h00;
      else
         cnt <= srec ? cnt + 8'h01 : 8'h00;
   end
   default clocking dc @(posedge clk); endclocking
   default disable iff (!rst_b);
   wake_level_a: assert property (
      cke [*5] |-> input_active) else $error("enable not seen");
   self_entry_a: assert property (
      $fell(cke) && rfp && idl && nrm |-> ##[1:5] slf)
      else $error("no self-refresh entry");
   self_hold_a: assert property (
      (!cke) [*4] ##0 slf |=> slf && refresh_pulse)
      else $error("self-refresh left or silent");
   recov_time_a: assert property (
      $fell(srec) && nrm |-> cnt >= ROW_CYCLES - 2 && cnt <= ROW_CYCLES + 3)
      else $error("recovery length wrong");
   recov_pdown_a: assert property (
      srec && $fell(cke) && (cs_b || (ras_b && cas_b)) |-> ##[1:6] pdn)
      else $error("no power-down from recovery");
   pdown_exit_a: assert property (
      pdn && $rose(cke) |-> ##[1:5] nrm) else $error("power-down stuck");
   susp_entry_a: assert property (
      $fell(cke) && !idl && nrm |-> ##[1:5] sus)
      else $error("no suspend");
   susp_freeze_a: assert property (
      sus && $past(sus) |=> $stable(bank0_state) && $stable(bank1_state))
      else $error("bank moved in suspend");
   susp_resume_a: assert property (
      sus && $rose(cke) |-> ##[1:5] nrm) else $error("suspend stuck");
   open_bank_a: assert property (
      cke && !cs_b && !ras_b && cas_b && we_b && addr[11] && nrm &&
      bank1_state == 3'h0 |-> ##[2:5] bank1_state == 3'h1 && cmd_bank)
      else $error("open missed bank");
endmodule // sdcc_decode_assertions

bind sdcc_decode sdcc_decode_assertions #(.ROW_CYCLES(ROW_CYCLES),
   .BURST_LEN(BURST_LEN)) u_chk (.clk(clk), .rst_b(rst_b), .cke(cke),
   .cs_b(cs_b), .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b), .addr(addr),
   .dev_state(dev_state), .bank0_state(bank0_state),
   .bank1_state(bank1_state), .cmd_bank(cmd_bank),
   .refresh_pulse(refresh_pulse), .input_active(input_active));

//--- tb/sdcc_ctrl_model.sv
// Purpose: Controller model driving the decoder pins
// Assumes: Pins change on the falling edge
// Notes: Released address shows the inverse of the last value
`timescale 1ns/1ps
module sdcc_ctrl_model #(
   parameter WAKE_CYC = 2
) (
   input wire clk,
   output reg cke,
   output reg cs_b,
   output reg ras_b,
   output reg cas_b,
   output reg we_b,
   output reg [11:0] addr
);
   initial begin
      cke = 1'b1;
      {cs_b, ras_b, cas_b, we_b} = 4'hF;
      addr = 12'h000;
   end
   // One command cycle then idle; after a wake it holds off commands
   task cmd(input k, input [3:0] p, input [11:0] a);
      reg was;
      begin
         was = cke;
         @(negedge clk);
         cke <= k;
         {cs_b, ras_b, cas_b, we_b} <= p;
         addr <= a;
         @(negedge clk);
         {cs_b, ras_b, cas_b, we_b} <= 4'h7;
         addr <= ~a;
         if (k && !was)
            repeat (WAKE_CYC) @(negedge clk);
      end
   endtask
endmodule // sdcc_ctrl_model

//--- tb/sdram_cke_command_decode_tb.sv
// Purpose: Self-checking bench of the command decoder
// Assumes: Controller model drives every command pin; the bench drives clock and reset
// Notes: Expected states queue up; a watcher retires them
`timescale 1ns/1ps
module sdram_cke_command_decode_tb;
   reg clk = 1'b0;
   reg rst_b = 1'b0;
   reg ill = 1'b0;
   wire cke, cs_b, ras_b, cas_b, we_b, cmd_bank, illegal_cmd;
   wire refresh_pulse, input_active;
   wire [11:0] addr, config_word;
   wire [2:0] dev_state, bank0_state, bank1_state;
   wire [10:0] row_addr;
   wire [9:0] col_addr;
   integer n_fail = 0, n_tests = 0, w = 0, j;
   reg [11:0] q[$];
   reg [11:0] r;
   wire [11:0] st = {1'b0, dev_state, 1'b0, bank0_state, 1'b0, bank1_state};
   initial forever #2.5 clk = ~clk;
   sdcc_ctrl_model ctl (.clk(clk), .cke(cke), .cs_b(cs_b), .ras_b(ras_b),
      .cas_b(cas_b), .we_b(we_b), .addr(addr));
   sdcc_decode #(.ROW_CYCLES(8), .BURST_LEN(4)) dut (.clk(clk),
      .rst_b(rst_b), .cke(cke), .cs_b(cs_b), .ras_b(ras_b), .cas_b(cas_b),
      .we_b(we_b), .addr(addr), .dev_state(dev_state),
      .bank0_state(bank0_state), .bank1_state(bank1_state),
      .config_word(config_word), .row_addr(row_addr), .col_addr(col_addr),
      .cmd_bank(cmd_bank), .illegal_cmd(illegal_cmd),
      .refresh_pulse(refresh_pulse), .input_active(input_active));
   // Remembers any illegal-pattern flag
   always @(posedge clk) if (illegal_cmd) ill <= 1'b1;
   task results;
      begin
         $display("tests %0d failures %0d", n_tests, n_fail);
         if (n_fail == 0 && n_tests > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   task bad(input [11:0] g, input [11:0] e);
      begin
         n_fail = n_fail + 1;
         $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task chk(input [11:0] g, input [11:0] e);
      begin
         n_tests = n_tests + 1;
         if (g !== e) bad(g, e);
      end
   endtask
   // Notes a state {dev,bank0,bank1} and waits until it is retired
   task ex(input [11:0] e);
      integer k;
      begin
         q.push_back(e);
         for (k = 0; k < 100 && q.size() > 0; k = k + 1) @(posedge clk);
         if (q.size() > 0) begin
            bad(st, q[0]);
            results;
         end
      end
   endtask
   // Retires the oldest note once the states match it, bounded
   always @(negedge clk) begin
      if (q.size() > 0) begin
         w = w + 1;
         if (st === q[0]) begin
            n_tests = n_tests + 1;
            void'(q.pop_front());
            w = 0;
         end else if (w > 60) begin
            bad(st, q[0]);
            results;
         end
      end
   end
   initial begin
      void'($urandom(32'h15C6));
      repeat (6) @(posedge clk);
      @(negedge clk) rst_b <= 1'b1;
      ex(12'h000);
      r = 12'($urandom);
      ctl.cmd(1'b1, 4'h0, r);
      repeat (4) @(negedge clk);
      chk(config_word, r);
      ctl.cmd(1'b1, 4'h1, 12'h000);
      repeat (2) @(negedge clk);
      chk({11'h000, refresh_pulse}, 12'h001);
      @(negedge clk);
      chk({11'h000, refresh_pulse}, 12'h000);
      $display("test config done");
      r = 12'($urandom) | 12'h800;
      ctl.cmd(1'b1, 4'h3, r);
      ex(12'h001);
      chk({1'b0, row_addr}, r & 12'h7FF);
      r = 12'($urandom) | 12'hC00;
      ctl.cmd(1'b1, 4'h5, r);
      ex(12'h004);
      chk({2'h0, col_addr}, r & 12'h3FF);
      ex(12'h000);
      ctl.cmd(1'b1, 4'h3, 12'h0A5);
      ctl.cmd(1'b1, 4'h3, 12'h85A);
      ctl.cmd(1'b1, 4'h4, 12'h012);
      ex(12'h031);
      ex(12'h011);
      $display("test banks done");
      // Suspend in mid-burst: bank 0 must hold its read state
      ctl.cmd(1'b1, 4'h5, 12'h000);
      ctl.cmd(1'b0, 4'h7, 12'h000);
      ex(12'h421);
      ctl.cmd(1'b1, 4'h7, 12'h000);
      ex(12'h021);
      ex(12'h011);
      ctl.cmd(1'b1, 4'h2, 12'h800);
      ex(12'h010);
      ctl.cmd(1'b1, 4'h3, 12'h800);
      ex(12'h011);
      ctl.cmd(1'b1, 4'h2, 12'h400);
      ex(12'h000);
      $display("test suspend done");
      // Both banks are idle before each low-power entry
      ctl.cmd(1'b0, 4'h1, 12'h000);
      ex(12'h100);
      for (j = 0; j < 3; j = j + 1)
         ctl.cmd(1'b0, 4'($urandom), 12'($urandom));
      ex(12'h100);
      ctl.cmd(1'b1, 4'hF, 12'h000);
      ex(12'h200);
      ex(12'h000);
      ctl.cmd(1'b0, 4'h1, 12'h000);
      ex(12'h100);
      ctl.cmd(1'b1, 4'h7, 12'h000);
      ex(12'h200);
      ctl.cmd(1'b0, 4'h7, 12'h000);
      ex(12'h300);
      ctl.cmd(1'b1, 4'($urandom), 12'($urandom));
      ex(12'h000);
      ctl.cmd(1'b0, 4'hF, 12'h000);
      ex(12'h300);
      ctl.cmd(1'b1, 4'($urandom), 12'($urandom));
      ex(12'h000);
      ctl.cmd(1'b0, 4'h1, 12'h000);
      ex(12'h100);
      chk({11'h000, ill}, 12'h000);
      ctl.cmd(1'b1, 4'h5, 12'h000);
      repeat (4) @(negedge clk);
      chk({11'h000, ill}, 12'h001);
      $display("test lowpower done");
      results;
   end
endmodule // sdram_cke_command_decode_tb
